// ---- design/star_irq_pkg.sv ----
package star_irq_pkg;

   // -----------------------------------------------------------------
   // Interrupt status word layout
   // -----------------------------------------------------------------
   localparam int          IRQ_WIDTH      = 12;
   localparam int          BIT_POWER_ON   = 11;
   localparam int          BIT_ANY_WAKE   = 10;
   localparam int          BIT_BRANCH_TOP = 9;
   localparam int          BIT_UNDERVOLT  = 5;
   localparam int          BIT_CLAMP      = 4;
   localparam int          BIT_SERIAL_ERR = 3;
   localparam int          BIT_BAD_CMD    = 2;
   localparam int          BIT_OVERTEMP   = 1;
   localparam int          BIT_PARITY     = 0;
   localparam logic [11:0] IRQ_RESET      = 12'h001;

   // Bits cleared by a good read alone; the rest also need quiet sources
   localparam logic [11:0] READ_CLEAR_MASK = 12'hC0C;
   localparam logic [11:0] COND_CLEAR_MASK = 12'h3F2;

   // -----------------------------------------------------------------
   // Source flag layout
   // -----------------------------------------------------------------
   localparam int BRANCH_COUNT    = 4;
   localparam int GEN_FLAGS       = 10;
   localparam int G_LOCAL_WAKE    = 0;
   localparam int G_IC_WAKE       = 1;
   localparam int G_BATTERY_LOW   = 2;
   localparam int G_CORE_LOW      = 3;
   localparam int G_IO_LOW        = 4;
   localparam int G_TEMP_WARN     = 5;
   localparam int G_TEMP_HIGH     = 6;
   localparam int G_IC_STUCK      = 7;
   localparam int G_TX_STUCK      = 8;
   localparam int G_IC_COLLISION  = 9;
   localparam int BR_FLAGS        = 3;
   localparam int BR_WAKE         = 0;
   localparam int BR_FAULT        = 1;
   localparam int BR_STUCK        = 2;

   // Flags that the error-reset control clears
   localparam logic [9:0]  GEN_ERROR_MASK = 10'h3FC;
   localparam logic [2:0]  BR_ERROR_MASK  = 3'h6;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS  = 25;
   localparam int          IRQ_LOW_NS     = 50;
   localparam int          IRQ_LOW_CYCLES =
      (IRQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          FRAME_CLOCKS   = 16;
   localparam int          FRAME_CNT_W    = 5;
   localparam logic        FRAME_OK_RESET = 1'b1;

endpackage : star_irq_pkg

// ---- design/frame_check_if.sv ----
`timescale 1ns/10ps
interface frame_check_if;
   logic frame_error;
   logic frame_good;

   modport checker_end (output frame_error, output frame_good);
   modport status_end  (input  frame_error, input  frame_good);
endinterface : frame_check_if

// ---- design/serial_frame_check.sv ----
`timescale 1ns/10ps
module serial_frame_check (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   // Serial port pins
   input  wire logic               serial_select_n_in,
   input  wire logic               serial_clk_in,
   // Frame result
   frame_check_if.checker_end      result
);

   typedef struct packed {
      logic                                 sel_meta;
      logic                                 sel_sync;
      logic                                 sel_prev;
      logic                                 clk_meta;
      logic                                 clk_sync;
      logic                                 clk_prev;
      logic [star_irq_pkg::FRAME_CNT_W-1:0] count;
      logic                                 frame_error;
      logic                                 frame_good;
   } check_t;

   check_t s_q;
   check_t s_d;

   always_comb begin
      s_d             = s_q;
      s_d.sel_meta    = serial_select_n_in;
      s_d.sel_sync    = s_q.sel_meta;
      s_d.sel_prev    = s_q.sel_sync;
      s_d.clk_meta    = serial_clk_in;
      s_d.clk_sync    = s_q.clk_meta;
      s_d.clk_prev    = s_q.clk_sync;
      s_d.frame_error = 1'b0;
      // Select falling: new frame
      if (!s_q.sel_sync && s_q.sel_prev) begin
         s_d.count = '0;
      end else if (!s_q.sel_sync && s_q.clk_sync && !s_q.clk_prev) begin
         // Saturate so long frames never wrap back to a good count
         if (s_q.count != {star_irq_pkg::FRAME_CNT_W{1'b1}}) begin
            s_d.count = s_q.count + 5'h01;
         end
      end
      // Select rising: judge the clock count
      if (s_q.sel_sync && !s_q.sel_prev) begin
         s_d.frame_good  = (s_q.count == 5'(star_irq_pkg::FRAME_CLOCKS)); // R14
         s_d.frame_error = (s_q.count != 5'(star_irq_pkg::FRAME_CLOCKS)); // R14
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q            <= '0;
         s_q.sel_meta   <= 1'b1;
         s_q.sel_sync   <= 1'b1;
         s_q.sel_prev   <= 1'b1;
         s_q.frame_good <= star_irq_pkg::FRAME_OK_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign result.frame_error = s_q.frame_error;
   assign result.frame_good  = s_q.frame_good;

endmodule : serial_frame_check

// ---- design/star_irq_status.sv ----
`timescale 1ns/10ps
// Operation
// R1: Any newly set bit pulses interrupt pin low
// R2: Power, wake, serial, command bits clear on read
// R3: Other bits clear after sources gone, then read
// R4: Fixed twelve-bit layout of event bits
// R5: Bit zero gives odd parity over word
// R6: Power-on set when leaving off or reset
// R7: Any-wake set by branch, intercoupler, local wake
// R8: Branch event set by wake, fault or stuck
// R9: Branch event clear pulses pin unless wake-caused
// R10: Undervoltage set by battery, core or I/O
// R11: Undervoltage clear pulses interrupt pin
// R12: Clamp set by stuck lines or intercoupler collision
// R13: Clamp clear pulses interrupt pin
// R14: Host gives sixteen clocks; else serial error
// R15: Illegal mode request sets bad-command bit
// R16: Overtemperature set by warning or high flag
// R17: Overtemperature clear pulses interrupt pin
// R18: Latching holds source flags until their read
// R19: Error-reset clears error source flags
// R20: Pin idles high; low pulses last cycles
module star_irq_status (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Serial host port pins
   input  wire logic        serial_select_n_in,
   input  wire logic        serial_clk_in,
   // Register read strobes from host port
   input  wire logic        irq_status_read_in,
   input  wire logic        general_status_read_in,
   input  wire logic        branch_status_read_in,
   // Control bits
   input  wire logic        latch_enable_in,
   input  wire logic        error_reset_in,
   // Mode machine
   input  wire logic        unpowered_state_in,
   input  wire logic        held_in_reset_state_in,
   input  wire logic        bad_command_in,
   // General source flags
   input  wire logic        local_pin_wake_flag_in,
   input  wire logic        intercoupler_wake_flag_in,
   input  wire logic        battery_low_flag_in,
   input  wire logic        core_supply_low_flag_in,
   input  wire logic        io_supply_low_flag_in,
   input  wire logic        temp_warn_flag_in,
   input  wire logic        temp_high_flag_in,
   input  wire logic        intercoupler_stuck_flag_in,
   input  wire logic        tx_enable_stuck_flag_in,
   input  wire logic        intercoupler_collision_flag_in,
   // Branch source flags, bit i is branch i+1
   input  wire logic [3:0]  branch_wake_flag_in,
   input  wire logic [3:0]  branch_bus_fault_flag_in,
   input  wire logic [3:0]  branch_stuck_flag_in,
   // Interrupt pin and status views
   output logic             irq_n_pin_out,
   output logic [11:0]      irq_status_out,
   output logic [9:0]       general_flags_out,
   output logic [11:0]      branch_flags_out
);

   localparam int NB = star_irq_pkg::BRANCH_COUNT;
   localparam int NG = star_irq_pkg::GEN_FLAGS;
   localparam int NF = star_irq_pkg::BR_FLAGS;

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      PIN_IDLE = 3'b001,
      PIN_LOW  = 3'b010,
      PIN_GAP  = 3'b100
   } pin_state_t;

   typedef struct packed {
      logic [NG-1:0]    gen_held;
      logic [NB*NF-1:0] br_held;
      logic [11:1]      src_prev;
      logic [11:1]      irq;
      logic [9:6]       wake_only;
      logic [11:0]      status;
      logic [9:0]       gen_view;
      logic [11:0]      br_view;
      pin_state_t       pin_state;
      logic [3:0]       low_cnt;
      logic             pending;
      logic             irq_n;
   } state_t;

   state_t s_q;
   state_t s_d;

   frame_check_if frame ();

   serial_frame_check u_frame (
      .clk_in             (clk_in),
      .rst_n_in           (rst_n_in),
      .serial_select_n_in (serial_select_n_in),
      .serial_clk_in      (serial_clk_in),
      .result             (frame.checker_end)
   );

   // -----------------------------------------------------------------
   // Live source flags
   // -----------------------------------------------------------------
   logic [NG-1:0]    gen_live;
   logic [NB*NF-1:0] br_live;

   assign gen_live = {intercoupler_collision_flag_in, tx_enable_stuck_flag_in,
                      intercoupler_stuck_flag_in, temp_high_flag_in,
                      temp_warn_flag_in, io_supply_low_flag_in,
                      core_supply_low_flag_in, battery_low_flag_in,
                      intercoupler_wake_flag_in, local_pin_wake_flag_in};

   genvar gb;
   generate
      for (gb = 0; gb < NB; gb++) begin : g_branch
         assign br_live[gb*NF+star_irq_pkg::BR_WAKE]  = branch_wake_flag_in[gb];
         assign br_live[gb*NF+star_irq_pkg::BR_FAULT] = branch_bus_fault_flag_in[gb];
         assign br_live[gb*NF+star_irq_pkg::BR_STUCK] = branch_stuck_flag_in[gb];
      end
   endgenerate

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   logic [NG-1:0]    gen_v;
   logic [NB*NF-1:0] br_v;
   logic [NG-1:0]    gen_clr;
   logic [NB*NF-1:0] br_clr;
   logic [11:1]      src;
   logic [11:1]      rise;
   logic [11:1]      clr;
   logic [11:1]      irq_next;
   logic             read_ok;
   logic             edge_req;
   logic             br_wake_any;
   logic             br_stuck_any;

   always_comb begin
      s_d          = s_q;
      br_wake_any  = 1'b0;
      br_stuck_any = 1'b0;
      src          = '0;
      edge_req     = 1'b0;

      // Latched copies: a read releases them, error-reset drops the errors
      gen_clr = {NG{general_status_read_in}} |
                ({NG{error_reset_in}} & star_irq_pkg::GEN_ERROR_MASK); // R19
      br_clr  = {(NB*NF){branch_status_read_in}} |
                ({(NB*NF){error_reset_in}} & {NB{star_irq_pkg::BR_ERROR_MASK}}); // R19
      // Set beats clear so an event in the read cycle survives
      s_d.gen_held = (s_q.gen_held & ~gen_clr) | (gen_live & {NG{latch_enable_in}}); // R18
      s_d.br_held  = (s_q.br_held & ~br_clr) | (br_live & {(NB*NF){latch_enable_in}}); // R18
      gen_v        = gen_live | (s_q.gen_held & {NG{latch_enable_in}}); // R18
      br_v         = br_live | (s_q.br_held & {(NB*NF){latch_enable_in}}); // R18
      s_d.gen_view = gen_v;
      s_d.br_view  = br_v;

      for (int b = 0; b < NB; b++) begin
         br_wake_any  = br_wake_any | br_v[b*NF+star_irq_pkg::BR_WAKE];
         br_stuck_any = br_stuck_any | br_v[b*NF+star_irq_pkg::BR_STUCK];
         src[star_irq_pkg::BIT_BRANCH_TOP-b] = |br_v[b*NF +: NF]; // R8
      end

      src[star_irq_pkg::BIT_POWER_ON] = ~(unpowered_state_in | held_in_reset_state_in); // R6
      src[star_irq_pkg::BIT_ANY_WAKE] = gen_v[star_irq_pkg::G_LOCAL_WAKE] |
                                        gen_v[star_irq_pkg::G_IC_WAKE] | br_wake_any; // R7
      src[star_irq_pkg::BIT_UNDERVOLT] = gen_v[star_irq_pkg::G_BATTERY_LOW] |
                                         gen_v[star_irq_pkg::G_CORE_LOW] |
                                         gen_v[star_irq_pkg::G_IO_LOW]; // R10
      src[star_irq_pkg::BIT_CLAMP] = gen_v[star_irq_pkg::G_IC_STUCK] |
                                     gen_v[star_irq_pkg::G_TX_STUCK] |
                                     gen_v[star_irq_pkg::G_IC_COLLISION] | br_stuck_any; // R12
      src[star_irq_pkg::BIT_SERIAL_ERR] = frame.frame_error; // R14
      src[star_irq_pkg::BIT_BAD_CMD]    = bad_command_in; // R15
      src[star_irq_pkg::BIT_OVERTEMP]   = gen_v[star_irq_pkg::G_TEMP_WARN] |
                                          gen_v[star_irq_pkg::G_TEMP_HIGH]; // R16

      s_d.src_prev = src;
      rise         = src & ~s_q.src_prev;

      // A read counts only when its frame carried sixteen clocks
      read_ok = irq_status_read_in & frame.frame_good;
      clr     = {11{read_ok}} & s_q.irq & ~rise &
                (star_irq_pkg::READ_CLEAR_MASK[11:1] |
                 (star_irq_pkg::COND_CLEAR_MASK[11:1] & ~src)); // R2 R3
      irq_next = (s_q.irq & ~clr) | rise;
      s_d.irq  = irq_next;

      // Remember whether a branch bit owes its state to a wake alone
      for (int b = 0; b < NB; b++) begin
         if (rise[star_irq_pkg::BIT_BRANCH_TOP-b] &&
             !s_q.irq[star_irq_pkg::BIT_BRANCH_TOP-b]) begin
            s_d.wake_only[star_irq_pkg::BIT_BRANCH_TOP-b] =
               ~br_v[b*NF+star_irq_pkg::BR_FAULT] & ~br_v[b*NF+star_irq_pkg::BR_STUCK];
         end else if (br_v[b*NF+star_irq_pkg::BR_FAULT] || br_v[b*NF+star_irq_pkg::BR_STUCK]) begin
            s_d.wake_only[star_irq_pkg::BIT_BRANCH_TOP-b] = 1'b0;
         end
      end

      edge_req = |(rise & ~s_q.irq); // R1
      if (|(clr[9:6] & ~s_q.wake_only)) begin
         edge_req = 1'b1; // R9
      end
      if (clr[star_irq_pkg::BIT_UNDERVOLT]) begin
         edge_req = 1'b1; // R11
      end
      if (clr[star_irq_pkg::BIT_CLAMP]) begin
         edge_req = 1'b1; // R13
      end
      if (clr[star_irq_pkg::BIT_OVERTEMP]) begin
         edge_req = 1'b1; // R17
      end

      s_d.status = {irq_next, ~^irq_next}; // R4 R5

      // -----------------------------------------------------------------
      // Interrupt pin: requests met during a pulse or gap share one queued falling edge
      // -----------------------------------------------------------------
      unique case (s_q.pin_state)
         PIN_IDLE: begin
            if (edge_req || s_q.pending) begin
               s_d.pin_state = PIN_LOW;
               s_d.irq_n     = 1'b0; // R1
               s_d.pending   = 1'b0;
               s_d.low_cnt   = 4'(star_irq_pkg::IRQ_LOW_CYCLES - 1); // R20
            end
         end
         PIN_LOW: begin
            s_d.pending = s_q.pending | edge_req;
            if (s_q.low_cnt == 4'h0) begin
               s_d.pin_state = PIN_GAP;
               s_d.irq_n     = 1'b1; // R20
            end else begin
               s_d.low_cnt = s_q.low_cnt - 4'h1;
            end
         end
         PIN_GAP: begin
            // Gap then idle keep the pin high two cycles so a queued request shows a fresh edge
            s_d.pending   = s_q.pending | edge_req;
            s_d.pin_state = PIN_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_q           <= '0;
         s_q.status    <= star_irq_pkg::IRQ_RESET;
         s_q.pin_state <= PIN_IDLE;
         s_q.irq_n     <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign irq_n_pin_out     = s_q.irq_n;
   assign irq_status_out    = s_q.status;
   assign general_flags_out = s_q.gen_view;
   assign branch_flags_out  = s_q.br_view;

endmodule : star_irq_status

// ---- testbench/star_irq_status_monitor.sv ----
`timescale 1ns/10ps
module star_irq_status_monitor (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Source flags
   input  wire logic        local_pin_wake_flag_in,
   input  wire logic        intercoupler_wake_flag_in,
   input  wire logic        battery_low_flag_in,
   input  wire logic        core_supply_low_flag_in,
   input  wire logic        io_supply_low_flag_in,
   input  wire logic        temp_warn_flag_in,
   input  wire logic        temp_high_flag_in,
   input  wire logic        intercoupler_stuck_flag_in,
   input  wire logic        tx_enable_stuck_flag_in,
   input  wire logic        intercoupler_collision_flag_in,
   input  wire logic [3:0]  branch_wake_flag_in,
   input  wire logic [3:0]  branch_bus_fault_flag_in,
   input  wire logic [3:0]  branch_stuck_flag_in,
   // Watched outputs
   input  wire logic        irq_n_pin_out,
   input  wire logic [11:0] irq_status_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // ------------------------------------------------------------
   // Pin pulse steps
   // ------------------------------------------------------------
   sequence s_low_pulse;
      !irq_n_pin_out ##1 irq_n_pin_out;
   endsequence
   // Queued requests may wait out a running pulse and its gap
   sequence s_irq_fall;
      ##[0:4] $fell(irq_n_pin_out);
   endsequence

   property p_pulse_len;
      $fell(irq_n_pin_out) |=> s_low_pulse;
   endproperty
   property p_parity;
      (^irq_status_out) == 1'h1;
   endproperty
   property p_set_irq;
      (|(irq_status_out[11:1] & ~$past(irq_status_out[11:1]))) |-> s_irq_fall;
   endproperty
   property p_uv_set;
      $rose(battery_low_flag_in) || $rose(core_supply_low_flag_in) ||
      $rose(io_supply_low_flag_in) |=> irq_status_out[5];
   endproperty
   property p_temp_set;
      $rose(temp_warn_flag_in) || $rose(temp_high_flag_in) |=> irq_status_out[1];
   endproperty
   property p_clamp_set;
      $rose(intercoupler_stuck_flag_in) || $rose(tx_enable_stuck_flag_in) ||
      $rose(intercoupler_collision_flag_in) ||
      (|(branch_stuck_flag_in & ~$past(branch_stuck_flag_in))) |=> irq_status_out[4];
   endproperty
   property p_wake_set;
      $rose(local_pin_wake_flag_in) || $rose(intercoupler_wake_flag_in) ||
      (|(branch_wake_flag_in & ~$past(branch_wake_flag_in))) |=> irq_status_out[10];
   endproperty
   property p_branch_set;
      $rose(branch_wake_flag_in[0] | branch_bus_fault_flag_in[0] | branch_stuck_flag_in[0])
      |=> irq_status_out[9];
   endproperty
   property p_uv_hold;
      irq_status_out[5] && (battery_low_flag_in || core_supply_low_flag_in ||
      io_supply_low_flag_in) |=> irq_status_out[5];
   endproperty
   property p_uv_clear;
      $fell(irq_status_out[5]) |-> s_irq_fall;
   endproperty
   property p_clamp_clear;
      $fell(irq_status_out[4]) |-> s_irq_fall;
   endproperty
   property p_temp_clear;
      $fell(irq_status_out[1]) |-> s_irq_fall;
   endproperty

   a_pulse_len: assert property (p_pulse_len)
      else $error("irq pulse length wrong");
   a_parity: assert property (p_parity)
      else $error("status parity not odd");
   a_set_irq: assert property (p_set_irq)
      else $error("new status bit without irq pulse");
   a_uv_set: assert property (p_uv_set)
      else $error("undervoltage bit not set");
   a_temp_set: assert property (p_temp_set)
      else $error("overtemperature bit not set");
   a_clamp_set: assert property (p_clamp_set)
      else $error("clamp bit not set");
   a_wake_set: assert property (p_wake_set)
      else $error("wake bit not set");
   a_branch_set: assert property (p_branch_set)
      else $error("branch one event bit not set");
   a_uv_hold: assert property (p_uv_hold)
      else $error("undervoltage bit cleared with source high");
   a_uv_clear: assert property (p_uv_clear)
      else $error("undervoltage clear without pulse");
   a_clamp_clear: assert property (p_clamp_clear)
      else $error("clamp clear without pulse");
   a_temp_clear: assert property (p_temp_clear)
      else $error("overtemperature clear without pulse");
endmodule : star_irq_status_monitor

// ---- testbench/serial_host_model.sv ----
`timescale 1ns/10ps
module serial_host_model (
   // Serial port pins
   output logic serial_select_n_out,
   output logic serial_clk_out
);
   localparam int HALF_NS = 100;

   // Clock stands low between frames
   initial begin
      serial_select_n_out = 1'h1;
      serial_clk_out      = 1'h0;
   end

   task send(input int clocks);
      serial_select_n_out = 1'h0;
      #(HALF_NS);
      repeat (clocks) begin
         serial_clk_out = 1'h1;
         #(HALF_NS);
         serial_clk_out = 1'h0;
         #(HALF_NS);
      end
      serial_select_n_out = 1'h1;
      #(HALF_NS);
   endtask : send
endmodule : serial_host_model

// ---- testbench/star_irq_status_bench.sv ----
`timescale 1ns/10ps
module star_irq_status_bench;
   localparam int WATCHDOG_NS = 200_000;
   logic        clk, rst_n, rd_irq, rd_gen, rd_br, latch_en, err_rst;
   logic        unpwr, held, bad_cmd, sel_n, sclk, irq_n;
   logic [9:0]  gen, gview;
   logic [3:0]  brw, brf, brs;
   logic [11:0] status, bview;
   int          errors, num_checks, falls;

   serial_host_model u_serial_host_model (
      .serial_select_n_out(sel_n), .serial_clk_out(sclk));
   star_irq_status u_star_irq_status (
      .clk_in(clk), .rst_n_in(rst_n), .serial_select_n_in(sel_n), .serial_clk_in(sclk),
      .irq_status_read_in(rd_irq), .general_status_read_in(rd_gen),
      .branch_status_read_in(rd_br), .latch_enable_in(latch_en), .error_reset_in(err_rst),
      .unpowered_state_in(unpwr), .held_in_reset_state_in(held), .bad_command_in(bad_cmd),
      .local_pin_wake_flag_in(gen[0]), .intercoupler_wake_flag_in(gen[1]),
      .battery_low_flag_in(gen[2]), .core_supply_low_flag_in(gen[3]),
      .io_supply_low_flag_in(gen[4]), .temp_warn_flag_in(gen[5]),
      .temp_high_flag_in(gen[6]), .intercoupler_stuck_flag_in(gen[7]),
      .tx_enable_stuck_flag_in(gen[8]), .intercoupler_collision_flag_in(gen[9]),
      .branch_wake_flag_in(brw), .branch_bus_fault_flag_in(brf), .branch_stuck_flag_in(brs),
      .irq_n_pin_out(irq_n), .irq_status_out(status), .general_flags_out(gview),
      .branch_flags_out(bview));

   always #12.5 clk = ~clk;
   always @(negedge irq_n) falls++;

   task step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : step

   task chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h got %h", name, exp, got);
      end
   endtask : chk

   task rd_status;
      rd_irq = 1'h1;
      step(1);
      rd_irq = 1'h0;
   endtask : rd_status

   function automatic logic [11:0] w(input logic [11:0] b);
      return {b[11:1], ~(^b[11:1])};
   endfunction : w

   // Sources 0..9 general, then branch b kind k at 10 + 3b + k
   function automatic logic [11:0] src_bits(input int i);
      int k;
      k = (i - 10) % 3;
      if (i < 2) return 12'h400;
      if (i < 5) return 12'h020;
      if (i < 7) return 12'h002;
      if (i < 10) return 12'h010;
      return (12'h200 >> ((i - 10) / 3)) | (k == 0 ? 12'h400 : 12'h000) |
             (k == 2 ? 12'h010 : 12'h000);
   endfunction : src_bits

   task set_src(input int i, input logic v);
      if (i < 10) gen[i] = v;
      else if ((i - 10) % 3 == 0) brw[(i - 10) / 3] = v;
      else if ((i - 10) % 3 == 1) brf[(i - 10) / 3] = v;
      else brs[(i - 10) / 3] = v;
   endtask : set_src

   task t_power;
      chk("por", w(12'h800), status);
      rd_status();
      step(3);
      chk("por_rd", 12'h001, status);
      unpwr = 1'h1;
      step(3);
      unpwr = 1'h0;
      step(3);
      chk("off_exit", w(12'h800), status);
      held = 1'h1;
      rd_status();
      step(3);
      held = 1'h0;
      step(3);
      chk("rst_exit", w(12'h800), status);
      rd_status();
      step(3);
   endtask : t_power

   task t_sources;
      int i, f;
      logic [11:0] e;
      for (i = 0; i < 22; i++) begin
         e = src_bits(i);
         f = falls;
         set_src(i, 1'h1);
         step(4);
         chk("set", w(e), status);
         rd_status();
         step(5);
         chk("held", w(e & star_irq_pkg::COND_CLEAR_MASK), status);
         set_src(i, 1'h0);
         rd_status();
         step(5);
         chk("cleared", 12'h001, status);
         chk("pulses", ((e & star_irq_pkg::COND_CLEAR_MASK) != 0 &&
             !(i >= 10 && (i - 10) % 3 == 0)) ? 12'h002 : 12'h001,
             12'(falls - f));
      end
   endtask : t_sources

   task t_serial;
      u_serial_host_model.send(15);
      step(8);
      chk("short", w(12'h008), status);
      rd_status();
      step(3);
      chk("refused", w(12'h008), status);
      u_serial_host_model.send(16);
      step(8);
      rd_status();
      step(3);
      chk("good", 12'h001, status);
      u_serial_host_model.send(17);
      step(8);
      chk("long", w(12'h008), status);
      u_serial_host_model.send(16);
      step(8);
      rd_status();
      step(3);
   endtask : t_serial

   task t_cmd_latch;
      bad_cmd = 1'h1;
      step(1);
      bad_cmd = 1'h0;
      step(3);
      chk("bad_cmd", w(12'h004), status);
      latch_en = 1'h1;
      rd_status();
      gen = 10'h021;
      brw = 4'h2;
      brf = 4'h2;
      step(1);
      gen = 10'h000;
      brw = 4'h0;
      brf = 4'h0;
      step(4);
      chk("gen_view", 12'h021, 12'(gview));
      chk("br_view", 12'h018, bview);
      err_rst = 1'h1;
      step(1);
      err_rst = 1'h0;
      step(3);
      chk("err_rst", 12'h001, 12'(gview));
      chk("br_err_rst", 12'h008, bview);
      rd_br = 1'h1;
      step(1);
      rd_br = 1'h0;
      step(3);
      chk("br_rel", 12'h000, bview);
      rd_gen = 1'h1;
      step(1);
      rd_gen = 1'h0;
      latch_en = 1'h0;
      step(3);
      chk("gen_rel", 12'h000, 12'(gview));
      rd_status();
      step(5);
      chk("all_clr", 12'h001, status);
   endtask : t_cmd_latch

   task end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      clk = 1'h0;
      rst_n = 1'h0;
      {rd_irq, rd_gen, rd_br, latch_en, err_rst, unpwr, held, bad_cmd} = 8'h00;
      {gen, brw, brf, brs} = 22'h000000;
      repeat (4) @(posedge clk);
      #2;
      rst_n = 1'h1;
      step(3);
      t_power();
      t_sources();
      t_serial();
      t_cmd_latch();
      end_sim();
   end

   initial begin
      #(WATCHDOG_NS);
      errors++;
      end_sim();
   end
endmodule : star_irq_status_bench

bind star_irq_status star_irq_status_monitor u_star_irq_status_monitor (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .local_pin_wake_flag_in(local_pin_wake_flag_in),
   .intercoupler_wake_flag_in(intercoupler_wake_flag_in),
   .battery_low_flag_in(battery_low_flag_in), .core_supply_low_flag_in(core_supply_low_flag_in),
   .io_supply_low_flag_in(io_supply_low_flag_in), .temp_warn_flag_in(temp_warn_flag_in),
   .temp_high_flag_in(temp_high_flag_in), .intercoupler_stuck_flag_in(intercoupler_stuck_flag_in),
   .tx_enable_stuck_flag_in(tx_enable_stuck_flag_in),
   .intercoupler_collision_flag_in(intercoupler_collision_flag_in),
   .branch_wake_flag_in(branch_wake_flag_in), .branch_bus_fault_flag_in(branch_bus_fault_flag_in),
   .branch_stuck_flag_in(branch_stuck_flag_in), .irq_n_pin_out(irq_n_pin_out),
   .irq_status_out(irq_status_out));
